/* alrf_formatter.sv */
`timescale 1ns/1ps
module alrf_formatter
	import alrf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [7:0] req_index,
	output logic req_ready,
	output logic req_error,
	output logic busy,
	output logic [7:0] rec_data,
	output logic rec_last,
	output logic rec_valid,
	input wire logic rec_ready,
	input wire logic online,
	input wire logic exchange_phase,
	input wire logic sample_valid,
	input wire logic sample_ok,
	input wire logic [4:0] sample_slave,
	input wire logic [1:0] sample_channel,
	input wire logic [15:0] sample_value,
	input wire logic out_valid,
	input wire logic [4:0] out_slave,
	input wire logic [1:0] out_channel,
	input wire logic [15:0] out_value
);
	alrf_stream_if #(.WIDTH(ALRF_FIFO_WIDTH)) fill_s ();
	alrf_stream_if #(.WIDTH(ALRF_FIFO_WIDTH)) drain_s ();

	// Channel word index = (slave-1)*4 + channel, so byte k-2 halves to it
	logic [15:0] in_image [0:ALRF_WORDS-1];
	logic [15:0] out_image [0:ALRF_WORDS-1];
	alrf_state_e state;
	logic [7:0] byte_cnt;
	logic sel_output;
	logic [7:0] low_hold;
	logic [7:0] body_off;
	logic [6:0] word_idx;
	logic [15:0] word;
	logic in_wr;
	logic out_wr;
	logic [6:0] in_idx;
	logic [6:0] out_idx;

	assign in_wr = sample_valid && sample_ok && online && exchange_phase && sample_slave != 5'h00;
	assign out_wr = out_valid && out_slave != 5'h00;
	assign in_idx = 7'({sample_slave - 5'h01, sample_channel});
	assign out_idx = 7'({out_slave - 5'h01, out_channel});

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < ALRF_WORDS; i++)
				in_image[i] <= ALRF_VALUE_RESET;
		end
		else if (in_wr)
			in_image[in_idx] <= sample_value;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < ALRF_WORDS; i++)
				out_image[i] <= ALRF_VALUE_RESET;
		end
		else if (out_wr)
			out_image[out_idx] <= out_value;
	end

	// Area of slave n at 2 + 8*(n-1); channel c at +2*c, high byte first
	assign body_off = byte_cnt - ALRF_AREA_BASE;
	assign word_idx = body_off[7:1];
	assign word = sel_output ? out_image[word_idx] : in_image[word_idx];

	always_comb
	begin
		fill_s.valid = state != ALRF_IDLE;
		if (state == ALRF_HEAD)
			fill_s.data = {1'b0, byte_cnt[0] ? ALRF_VERSION_LOW : ALRF_VERSION_HIGH};
		else if (body_off[0])
			fill_s.data = {byte_cnt == ALRF_LAST_BYTE, low_hold};
		else
			fill_s.data = {1'b0, word[15:8]};
	end

	// Low byte is held with its high byte so one channel never tears mid-update
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			low_hold <= ALRF_COUNT_RESET;
		else if (state == ALRF_BODY && fill_s.ready && !body_off[0])
			low_hold <= word[7:0];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= ALRF_IDLE;
			byte_cnt <= ALRF_COUNT_RESET;
			sel_output <= 1'b0;
		end
		else
		begin
			case (state)
				ALRF_IDLE:
				begin
					byte_cnt <= ALRF_COUNT_RESET;
					if (req_valid && (req_index == ALRF_IDX_INPUT || req_index == ALRF_IDX_OUTPUT))
					begin
						state <= ALRF_HEAD;
						sel_output <= req_index == ALRF_IDX_OUTPUT;
					end
				end
				ALRF_HEAD:
				begin
					if (fill_s.ready)
					begin
						byte_cnt <= byte_cnt + 8'h01;
						if (byte_cnt[0])
							state <= ALRF_BODY;
					end
				end
				ALRF_BODY:
				begin
					if (fill_s.ready)
					begin
						if (byte_cnt == ALRF_LAST_BYTE)
							state <= ALRF_IDLE;
						else
							byte_cnt <= byte_cnt + 8'h01;
					end
				end
				default:
					state <= ALRF_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			req_ready <= 1'b0;
			busy <= 1'b0;
			req_error <= 1'b0;
		end
		else
		begin
			req_ready <= state == ALRF_IDLE && !(req_valid && req_ready);
			// A refused index never raises busy; only a served record does
			busy <= state != ALRF_IDLE || (req_valid && req_ready && (req_index == ALRF_IDX_INPUT || req_index == ALRF_IDX_OUTPUT));
			// Only the two image records are served; any other index is refused
			req_error <= req_valid && req_ready && req_index != ALRF_IDX_INPUT && req_index != ALRF_IDX_OUTPUT;
		end
	end

	alrf_fifo #(.WIDTH(ALRF_FIFO_WIDTH), .DEPTH(ALRF_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_s(fill_s),
		.out_s(drain_s)
	);

	// Output stage keeps rec_data, rec_last and rec_valid on flops; costs one cycle of latency
	assign drain_s.ready = !rec_valid || rec_ready;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rec_valid <= 1'b0;
			rec_data <= ALRF_COUNT_RESET;
			rec_last <= 1'b0;
		end
		else if (drain_s.ready)
		begin
			rec_valid <= drain_s.valid;
			rec_data <= drain_s.data[7:0];
			rec_last <= drain_s.data[8] && drain_s.valid;
		end
	end
endmodule

/* alrf_pkg.sv */
// Notes on behaviour
// - Index 25 read returns whole-line analog input image
// - Eight bytes per slave, four two-byte channels
// - Slave 1 at byte 2, step 8, slave 31 at 242
// - Same layout serves the output record, index 26
// - Positions three, four: channels 3-4 or B half
// - Slaves 1 to 31, record ends at byte 249
// - Inputs stored only online, exchange phase, error-free
package alrf_pkg;

	localparam int ALRF_SLAVES = 31;
	localparam int ALRF_CHANNELS = 4;
	localparam int ALRF_AREA_BYTES = 8;
	localparam int ALRF_CHAN_BYTES = 2;
	localparam int ALRF_WORDS = ALRF_SLAVES * ALRF_CHANNELS;
	localparam logic [7:0] ALRF_AREA_BASE = 8'h02;
	localparam logic [7:0] ALRF_LAST_AREA_BASE = 8'hf2;
	localparam logic [7:0] ALRF_LAST_BYTE = 8'hf9;
	localparam logic [7:0] ALRF_IDX_INPUT = 8'h19;
	localparam logic [7:0] ALRF_IDX_OUTPUT = 8'h1a;
	localparam logic [7:0] ALRF_VERSION_HIGH = 8'h00;
	localparam logic [7:0] ALRF_VERSION_LOW = 8'h00;
	localparam logic [7:0] ALRF_COUNT_RESET = 8'h00;
	localparam logic [15:0] ALRF_VALUE_RESET = 16'h0000;
	localparam int ALRF_FIFO_DEPTH = 16;
	localparam int ALRF_FIFO_WIDTH = 9;

	typedef enum logic [1:0] {
		ALRF_IDLE = 2'b00,
		ALRF_HEAD = 2'b01,
		ALRF_BODY = 2'b10
	} alrf_state_e;

endpackage

/* alrf_stream_if.sv */
`timescale 1ns/1ps
interface alrf_stream_if #(parameter int WIDTH = 9);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

/* alrf_fifo.sv */
`timescale 1ns/1ps
module alrf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	alrf_stream_if.snk in_s,
	alrf_stream_if.src out_s
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	logic push;
	logic pop;

	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;
	assign in_s.ready = count != (PW+1)'(DEPTH);
	assign out_s.valid = count != '0;
	assign out_s.data = mem[rd_ptr];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_s.data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			count <= '0;
		else if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end
endmodule

/* alrf_formatter_props.sv */
`timescale 1ns/1ps
module alrf_formatter_props
	import alrf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [7:0] req_index,
	input wire logic req_ready,
	input wire logic req_error,
	input wire logic busy,
	input wire logic [7:0] rec_data,
	input wire logic rec_last,
	input wire logic rec_valid,
	input wire logic rec_ready
);
	logic [7:0] bcnt;
	wire take = req_valid && req_ready;
	wire good = req_index == ALRF_IDX_INPUT || req_index == ALRF_IDX_OUTPUT;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Byte position inside the record on the wire
	always_ff @(posedge clk)
		if (!rst_n || (rec_valid && rec_ready && rec_last))
			bcnt <= 8'h00;
		else if (rec_valid && rec_ready)
			bcnt <= bcnt + 8'h01;
	property p_bad; take && !good |=> req_error && !busy; endproperty
	a_bad: assert property (p_bad) else $error("bad index taken");
	property p_good; take && good |=> busy && !req_ready && !req_error; endproperty
	a_good: assert property (p_good) else $error("good index refused");
	property p_pulse; req_error |=> !req_error; endproperty
	a_pulse: assert property (p_pulse) else $error("error too long");
	property p_ready; busy |-> !req_ready; endproperty
	a_ready: assert property (p_ready) else $error("ready while busy");
	property p_hold; rec_valid && !rec_ready |=> rec_valid && $stable(rec_data); endproperty
	a_hold: assert property (p_hold) else $error("byte dropped");
	property p_ver; rec_valid && bcnt < 8'h02 |-> rec_data == ALRF_VERSION_HIGH; endproperty
	a_ver: assert property (p_ver) else $error("version not zero");
	property p_last; rec_valid |-> rec_last == (bcnt == ALRF_LAST_BYTE); endproperty
	a_last: assert property (p_last) else $error("last misplaced");
	property p_fin; take && good |-> ##[1:1000] rec_valid && rec_last; endproperty
	a_fin: assert property (p_fin) else $error("record unfinished");
	c_rec: cover property (rec_valid && rec_ready && rec_last);
	c_err: cover property (req_error);
	c_stall: cover property (rec_valid && !rec_ready);
endmodule
bind alrf_formatter alrf_formatter_props u_alrf_formatter_props (.*);

/* alrf_sink.sv */
`timescale 1ns/1ps
module alrf_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	output logic rec_ready
);
	logic [2:0] cnt;
	// Slow mode stalls two cycles in eight
	always_ff @(posedge clk)
	begin
		cnt <= rst_n ? cnt + 3'h1 : 3'h0;
		rec_ready <= !slow || cnt[2:1] != 2'h3;
	end
endmodule

/* analog_line_record_formatter_bench.sv */
`timescale 1ns/1ps
module analog_line_record_formatter_bench;
	logic clk = 0, rst_n = 0, req_valid = 0, online = 0, exchange_phase = 0, sample_valid = 0, sample_ok = 0;
	logic out_valid = 0, slow = 0, req_ready, req_error, busy, rec_last, rec_valid, rec_ready;
	logic [7:0] req_index = 0, rec_data;
	logic [4:0] sample_slave = 0, out_slave = 0;
	logic [1:0] sample_channel = 0, out_channel = 0;
	logic [15:0] sample_value = 0, out_value = 0;
	logic [15:0] img [2][32][4];
	logic [31:0] rng = 32'h6cf0;
	int fail_count = 0, checks_done = 0;
	always #50 clk = ~clk;
	alrf_formatter u_alrf_formatter (.*);
	alrf_sink u_alrf_sink (.*);
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task chk(string n, logic [15:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wr;
		rng = xs(rng);
		@(posedge clk);
		{sample_ok, online, exchange_phase, sample_slave, sample_channel, sample_value} <= rng[25:0];
		{out_slave, out_channel, out_value} <= ~rng[22:0];
		sample_valid <= 1'h1;
		out_valid <= 1'h1;
		if (rng[25:23] == 3'h7 && rng[22:18] != 5'h0)
			img[0][rng[22:18]][rng[17:16]] = rng[15:0];
		if (rng[22:18] != 5'h1f)
			img[1][~rng[22:18]][~rng[17:16]] = ~rng[15:0];
		@(posedge clk);
		sample_valid <= 1'h0;
		out_valid <= 1'h0;
	endtask
	task rd(logic [7:0] idx, logic bad);
		int k;
		logic [15:0] v;
		do @(negedge clk); while (req_ready !== 1'h1);
		@(posedge clk);
		req_valid <= 1'h1;
		req_index <= idx;
		@(posedge clk);
		req_valid <= 1'h0;
		@(negedge clk);
		chk("error", req_error, bad);
		k = 0;
		for (int n = 0; n < 2000 && k < 250 && !bad; n++)
		begin
			if (rec_valid && rec_ready)
			begin
				v = k < 2 ? 16'h0 : img[!idx[0]][(k - 2) / 8 + 1][(k - 2) % 8 / 2];
				chk("byte", rec_data, k[0] ? v[7:0] : v[15:8]);
				chk("last", rec_last, k == 249);
				k++;
			end
			@(negedge clk);
		end
		chk("count", 16'(k), bad ? 16'h0 : 16'hfa);
	endtask
	initial
	begin
		foreach (img[i, j, c]) img[i][j][c] = 16'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		rd(8'h19, 0);
		slow <= 1'h1;
		repeat (80) wr();
		rd(8'h19, 0);
		rd(8'h1a, 0);
		slow <= 1'h0;
		rd(8'h1b, 1);
		rd(8'h18, 1);
		rd(8'h1a, 0);
		give_verdict;
	end
	initial
	begin
		#(100 * 20000);
		fail_count++;
		give_verdict;
	end
endmodule
